// ---- rtl/link_quality_monitor.sv ----
// link quality monitor: thresholds, sticky warnings, restart request and interrupt
//
// The address-and-strobe port was chosen for this implementation.
`include "link_quality_monitor_regs.svh"

// Notes on behaviour
// - monitor runs only while enable bit 15 is set; resets to zero
// - no checking or warnings unless a valid 100 Mb link is present
// - threshold at its extreme value never flags a violation
// - violation raises interrupt when link quality interrupt enable and interrupt mask bit 0 are both set
// - reading monitor register clears warnings and re-arms the interrupt
// - bit 14 set: frequency control violation restarts receiver adaptation
// - bit 13 set: frequency offset violation restarts receiver adaptation
// - bit 12 set: baseline wander violation restarts receiver adaptation
// - bit 11 set: gain control violation restarts receiver adaptation
// - bit 10 set: equalizer coefficient violation restarts receiver adaptation
// - restart with signal detect option zero also drops link status
// - frequency control high warning bit 9, low warning bit 8
// - frequency offset high warning bit 7, low warning bit 6
// - baseline wander high warning bit 5, low warning bit 4
// - gain control high warning bit 3, low warning bit 2
// - equalizer coefficient high warning bit 1, low warning bit 0
// - threshold write strobe stores data into the selected threshold; reads zero
// - select 0 low, 1 high; codes 000 to 100 pick the five parameters
module link_quality_monitor (
	input  wire logic                               clk_sys,
	input  wire logic                               reset_n,
	input  wire logic [4:0]                         reg_addr,
	input  wire logic [15:0]                        reg_wdata,
	input  wire logic                               reg_wr,
	input  wire logic                               reg_rd,
	output logic      [15:0]                        reg_rdata,
	input  wire link_quality_monitor_pkg::param_set_t params,
	input  wire logic                               link_100_valid,
	input  wire logic                               signal_detect_option,
	input  wire logic                               link_quality_irq_en,
	output logic                                    dsp_restart,
	output logic                                    link_drop,
	output logic                                    irq
);

	localparam int NPARAM = 5;

	// control fields: enable and five restart enables
	logic                                    monitor_on;
	logic [4:0]                              restart_en;
	logic [9:0]                              warn;
	logic                                    freq_ctrl_high_flag;
	logic                                    freq_ctrl_low_flag;
	logic                                    freq_offset_high_flag;
	logic                                    freq_offset_low_flag;
	logic                                    baseline_high_flag;
	logic                                    baseline_low_flag;
	logic                                    gain_high_flag;
	logic                                    gain_low_flag;
	logic                                    coeff_high_flag;
	logic                                    coeff_low_flag;
	logic                                    armed;
	logic [1:0]                              irq_status;
	logic [1:0]                              irq_mask;
	logic [2:0]                              parameter_select;
	logic                                    threshold_high_low_select;
	logic signed [7:0]                       thr_low [NPARAM];
	logic signed [7:0]                       thr_high [NPARAM];
	link_quality_monitor_pkg::restart_state_t state;
	logic                                    restart_pulse;
	logic                                    drop_pulse;

	link_quality_monitor_pkg::reg_req_t req;
	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// strict compares: a high threshold at the maximum or a low one at the minimum never flags
	function automatic logic over_high(
		input logic                             on,
		input link_quality_monitor_pkg::param_t value,
		input link_quality_monitor_pkg::param_t limit
	);
		return on && (value > limit);
	endfunction : over_high

	function automatic logic under_low(
		input logic                             on,
		input link_quality_monitor_pkg::param_t value,
		input link_quality_monitor_pkg::param_t limit
	);
		return on && (value < limit);
	endfunction : under_low

	// sticky flag: a hit in the cycle of the clearing read still lands
	function automatic logic next_flag(
		input logic flag,
		input logic hit,
		input logic clear
	);
		return (flag && !clear) || hit;
	endfunction : next_flag

	// address decode
	wire ctrl_hit = (req.addr == `LQM_CTRL_ADDR);
	wire data_hit = (req.addr == `LQM_DATA_ADDR);
	wire stat_hit = (req.addr == `LQM_IRQ_STATUS_ADDR);
	wire mask_hit = (req.addr == `LQM_IRQ_MASK_ADDR);
	wire ctrl_read = req.rd && ctrl_hit;
	wire ctrl_write = req.wr && ctrl_hit;
	wire stat_write = req.wr && stat_hit;
	wire mask_write = req.wr && mask_hit;
	wire thr_write = req.wr && data_hit && req.wdata[`LQM_DATA_WRITE_BIT];
	wire [2:0] wr_sel = req.wdata[`LQM_DATA_PSEL_MSB:`LQM_DATA_PSEL_LSB];
	wire wr_hilo = req.wdata[`LQM_DATA_HILO_BIT];

	// gating: monitor runs only when enabled and the 100 Mb link is good
	wire checking = monitor_on && link_100_valid;

	// one named hit per warning field, raised only while checking
	wire freq_ctrl_high_hit   = over_high(checking, params.freq_ctrl, thr_high[4]);
	wire freq_ctrl_low_hit    = under_low(checking, params.freq_ctrl, thr_low[4]);
	wire freq_offset_high_hit = over_high(checking, params.freq_offset, thr_high[3]);
	wire freq_offset_low_hit  = under_low(checking, params.freq_offset, thr_low[3]);
	wire baseline_high_hit    = over_high(checking, params.baseline, thr_high[2]);
	wire baseline_low_hit     = under_low(checking, params.baseline, thr_low[2]);
	wire gain_high_hit        = over_high(checking, params.gain, thr_high[1]);
	wire gain_low_hit         = under_low(checking, params.gain, thr_low[1]);
	wire coeff_high_hit       = over_high(checking, params.coeff, thr_high[0]);
	wire coeff_low_hit        = under_low(checking, params.coeff, thr_low[0]);

	// hits in warning-field order, high above low
	wire [9:0] viol = {freq_ctrl_high_hit, freq_ctrl_low_hit, freq_offset_high_hit, freq_offset_low_hit,
		baseline_high_hit, baseline_low_hit, gain_high_hit, gain_low_hit, coeff_high_hit, coeff_low_hit};

	// restart enables by name, frequency control in the top bit
	wire offset_viol_a_ctrl_viol   = restart_en[4];
	wire offset_viol_a_offset_viol = restart_en[3];
	wire restart_on_baseline_viol    = restart_en[2];
	wire restart_on_gain_viol        = restart_en[1];
	wire restart_on_coeff_viol       = restart_en[0];

	// a violation restarts only where its parameter's restart bit is set
	wire [4:0] restart_hit;
	assign restart_hit[4] = offset_viol_a_ctrl_viol && (freq_ctrl_high_hit || freq_ctrl_low_hit);
	assign restart_hit[3] = offset_viol_a_offset_viol && (freq_offset_high_hit || freq_offset_low_hit);
	assign restart_hit[2] = restart_on_baseline_viol && (baseline_high_hit || baseline_low_hit);
	assign restart_hit[1] = restart_on_gain_viol && (gain_high_hit || gain_low_hit);
	assign restart_hit[0] = restart_on_coeff_viol && (coeff_high_hit || coeff_low_hit);
	wire any_viol = |viol;
	wire any_restart = |restart_hit;

	// warning field as read back, assembled from the sticky flags
	assign warn = {freq_ctrl_high_flag, freq_ctrl_low_flag, freq_offset_high_flag, freq_offset_low_flag,
		baseline_high_flag, baseline_low_flag, gain_high_flag, gain_low_flag, coeff_high_flag, coeff_low_flag};

	// interrupt fires once per armed period; a read re-arms
	wire viol_event = any_viol && armed && link_quality_irq_en;
	wire next_armed = ctrl_read ? 1'b1 : (armed && !viol_event);

	// status: write one to clear, a new event wins
	wire [1:0] st_clr = stat_write ? req.wdata[1:0] : 2'h0;
	wire [1:0] st_set = {restart_pulse, viol_event};
	wire [1:0] next_irq_status = (irq_status & ~st_clr) | st_set;

	// control register and interrupt arm flag
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			monitor_on <= 1'b0;
			restart_en <= 5'h00;
			armed      <= 1'b1;
		end
		else
		begin
			if (ctrl_write)
			begin
				monitor_on <= req.wdata[`MONITOR_ON_BIT];
				restart_en <= req.wdata[`LQM_RESTART_FC_BIT:`LQM_RESTART_LSB];
			end
			armed <= next_armed;
		end
	end

	// frequency control warning pair; a read clears both
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			freq_ctrl_high_flag <= 1'b0;
			freq_ctrl_low_flag  <= 1'b0;
		end
		else
		begin
			freq_ctrl_high_flag <= next_flag(freq_ctrl_high_flag, freq_ctrl_high_hit, ctrl_read);
			freq_ctrl_low_flag  <= next_flag(freq_ctrl_low_flag, freq_ctrl_low_hit, ctrl_read);
		end
	end

	// frequency offset warning pair
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			freq_offset_high_flag <= 1'b0;
			freq_offset_low_flag  <= 1'b0;
		end
		else
		begin
			freq_offset_high_flag <= next_flag(freq_offset_high_flag, freq_offset_high_hit, ctrl_read);
			freq_offset_low_flag  <= next_flag(freq_offset_low_flag, freq_offset_low_hit, ctrl_read);
		end
	end

	// baseline wander warning pair
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			baseline_high_flag <= 1'b0;
			baseline_low_flag  <= 1'b0;
		end
		else
		begin
			baseline_high_flag <= next_flag(baseline_high_flag, baseline_high_hit, ctrl_read);
			baseline_low_flag  <= next_flag(baseline_low_flag, baseline_low_hit, ctrl_read);
		end
	end

	// gain control warning pair
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			gain_high_flag <= 1'b0;
			gain_low_flag  <= 1'b0;
		end
		else
		begin
			gain_high_flag <= next_flag(gain_high_flag, gain_high_hit, ctrl_read);
			gain_low_flag  <= next_flag(gain_low_flag, gain_low_hit, ctrl_read);
		end
	end

	// equalizer coefficient warning pair
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			coeff_high_flag <= 1'b0;
			coeff_low_flag  <= 1'b0;
		end
		else
		begin
			coeff_high_flag <= next_flag(coeff_high_flag, coeff_high_hit, ctrl_read);
			coeff_low_flag  <= next_flag(coeff_low_flag, coeff_low_hit, ctrl_read);
		end
	end

	// data register selects and threshold storage
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			parameter_select          <= 3'h0;
			threshold_high_low_select <= 1'b0;
			for (int i = 0; i < NPARAM; i++)
			begin
				thr_low[i]  <= `LQM_THR_LOW_RESET;
				thr_high[i] <= `LQM_THR_HIGH_RESET;
			end
		end
		else if (req.wr && data_hit)
		begin
			parameter_select          <= wr_sel;
			threshold_high_low_select <= wr_hilo;
			// codes above 100 select nothing and are dropped
			if (thr_write && (wr_sel <= 3'h4))
			begin
				if (wr_hilo)
					thr_high[wr_sel] <= req.wdata[7:0];
				else
					thr_low[wr_sel] <= req.wdata[7:0];
			end
		end
	end

	// restart sequencer: one restart pulse, then wait until no restart-enabled violation remains
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			state         <= link_quality_monitor_pkg::ST_IDLE;
			restart_pulse <= 1'b0;
			drop_pulse    <= 1'b0;
		end
		else
		begin
			restart_pulse <= 1'b0;
			drop_pulse    <= 1'b0;
			case (state)
				link_quality_monitor_pkg::ST_IDLE:
					if (any_restart)
					begin
						restart_pulse <= 1'b1;
						drop_pulse    <= !signal_detect_option;
						state         <= link_quality_monitor_pkg::ST_RESTART;
					end
				// avoids retriggering while the receiver is re-adapting
				link_quality_monitor_pkg::ST_RESTART:
					state <= link_quality_monitor_pkg::ST_HOLD;
				link_quality_monitor_pkg::ST_HOLD:
					if (!any_restart)
						state <= link_quality_monitor_pkg::ST_IDLE;
				default:
					state <= link_quality_monitor_pkg::ST_IDLE;
			endcase
		end
	end

	// threshold shown by a data register read; codes above 100 fall back to the coefficient pair
	wire [2:0] read_sel  = (parameter_select <= 3'h4) ? parameter_select : 3'h0;
	wire [7:0] thr_shown = threshold_high_low_select ? thr_high[read_sel] : thr_low[read_sel];

	// read mux; write strobe always reads zero
	logic [15:0] next_rdata;
	always_comb
	begin
		next_rdata = 16'h0000;
		if (req.rd)
		begin
			if (ctrl_hit)
				next_rdata = {monitor_on, restart_en, warn};
			else if (data_hit)
				next_rdata = {4'h0, parameter_select, threshold_high_low_select, thr_shown};
			else if (stat_hit)
				next_rdata = {14'h0000, irq_status};
			else if (mask_hit)
				next_rdata = {14'h0000, irq_mask};
		end
	end

	// interrupt status and mask registers; a new event beats the write-one clear
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			irq_status <= `LQM_IRQ_RESET;
			irq_mask   <= `LQM_IRQ_RESET;
		end
		else
		begin
			irq_status <= next_irq_status;
			if (mask_write)
				irq_mask <= req.wdata[1:0];
		end
	end

	// outputs, all straight from flip-flops
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			reg_rdata   <= 16'h0000;
			dsp_restart <= 1'b0;
			link_drop   <= 1'b0;
			irq         <= 1'b0;
		end
		else
		begin
			reg_rdata   <= next_rdata;
			dsp_restart <= restart_pulse;
			link_drop   <= drop_pulse;
			irq         <= |(next_irq_status & irq_mask);
		end
	end

endmodule : link_quality_monitor

// ---- rtl/link_quality_monitor_pkg.sv ----
// types shared by the link quality monitor
package link_quality_monitor_pkg;

	// one adapted parameter is a signed byte
	typedef logic signed [7:0] param_t;

	// the five monitored parameters in parameter_select order
	typedef struct packed {
		param_t freq_ctrl;
		param_t freq_offset;
		param_t baseline;
		param_t gain;
		param_t coeff;
	} param_set_t;

	// register bus request
	typedef struct packed {
		logic [4:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	// parameter_select codes
	typedef enum logic [2:0] {
		SEL_COEFF       = 3'b000,
		SEL_GAIN        = 3'b001,
		SEL_BASELINE    = 3'b010,
		SEL_FREQ_OFFSET = 3'b011,
		SEL_FREQ_CTRL   = 3'b100
	} param_sel_t;

	// restart sequencer
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_RESTART = 2'b01,
		ST_HOLD    = 2'b10
	} restart_state_t;

endpackage : link_quality_monitor_pkg

// ---- rtl/link_quality_monitor_regs.svh ----
// register offsets, field positions and reset values of the link quality monitor
`ifndef LINK_QUALITY_MONITOR_REGS_SVH
`define LINK_QUALITY_MONITOR_REGS_SVH

// monitor control register at its printed offset
`define LQM_CTRL_ADDR        5'h1D
// companion data register holding the threshold write port
`define LQM_DATA_ADDR        5'h1E
// interrupt status and mask of this block
`define LQM_IRQ_STATUS_ADDR  5'h1F
`define LQM_IRQ_MASK_ADDR    5'h1C

// control register fields
`define MONITOR_ON_BIT       15
`define LQM_RESTART_FC_BIT   14
`define LQM_RESTART_FO_BIT   13
`define LQM_RESTART_BLW_BIT  12
`define LQM_RESTART_GAIN_BIT 11
`define LQM_RESTART_COEF_BIT 10
`define LQM_RESTART_LSB      10
`define LQM_WARN_MSB         9

// data register fields
`define LQM_DATA_WRITE_BIT   12
`define LQM_DATA_PSEL_MSB    11
`define LQM_DATA_PSEL_LSB    9
`define LQM_DATA_HILO_BIT    8

// interrupt status bits
`define LQM_IRQ_VIOL_BIT     0
`define LQM_IRQ_RESTART_BIT  1

// reset values
`define LQM_CTRL_RESET       6'h00
`define LQM_THR_LOW_RESET    8'h80
`define LQM_THR_HIGH_RESET   8'h7F
`define LQM_IRQ_RESET        2'h0

`endif

// ---- testbench/link_quality_monitor_sva.sv ----
// assertion checker on the ports of the link quality monitor
module link_quality_monitor_sva (
	input wire logic		clk_sys,
	input wire logic		reset_n,
	input wire logic [4:0]	reg_addr,
	input wire logic [15:0]	reg_wdata,
	input wire logic		reg_wr,
	input wire logic		reg_rd,
	input wire logic [15:0]	reg_rdata,
	input wire logic		link_100_valid,
	input wire logic		signal_detect_option,
	input wire logic		dsp_restart,
	input wire logic		link_drop,
	input wire logic		irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// one monitor clock domain, so the default clocking covers every check
	strobe_zero_a: assert property (reg_rd && reg_addr == 5'h1E |=> !reg_rdata[12]) else $error("strobe read high");
	drop_with_restart_a: assert property (link_drop |-> dsp_restart) else $error("drop without restart");
	drop_on_sd_a: assert property (dsp_restart && !$past(signal_detect_option, 2) |-> link_drop)
		else $error("restart without drop");
	sd_keeps_link_a: assert property (link_drop |-> !$past(signal_detect_option, 2))
		else $error("drop with option set");
	restart_pulse_a: assert property (dsp_restart |=> !dsp_restart) else $error("restart longer than a cycle");
	restart_link_a: assert property (dsp_restart |-> $past(link_100_valid, 2)) else $error("restart without link");
	mask_off_a: assert property (reg_wr && reg_addr == 5'h1C && reg_wdata[1:0] == 2'h0 |=> ##1 !irq)
		else $error("irq after mask cleared");
	irq_hold_a: assert property (irq && !reg_wr && !$past(reg_wr) |=> irq) else $error("irq fell alone");
endmodule : link_quality_monitor_sva

bind link_quality_monitor link_quality_monitor_sva i_sva (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_100_valid(link_100_valid),
	.signal_detect_option(signal_detect_option), .dsp_restart(dsp_restart),
	.link_drop(link_drop), .irq(irq));

// ---- testbench/test_link_quality_monitor.sv ----
// self-checking bench for the link quality monitor register block
module test_link_quality_monitor;
	timeunit 1ns;
	timeprecision 1ns;
	logic					clk_sys;
	logic					reset_n = 1'b0;
	logic [4:0]				reg_addr = 5'h00;
	logic [15:0]			reg_wdata = 16'h0000;
	logic					reg_wr = 1'b0;
	logic					reg_rd = 1'b0;
	logic [15:0]			reg_rdata;
	link_quality_monitor_pkg::param_set_t	params = '0;
	logic					link_ok = 1'b1;
	logic					sd_opt = 1'b0;
	logic					irq_en = 1'b0;
	logic					dsp_restart;
	logic					link_drop;
	logic					irq;
	int						failures = 0;
	int						samples_checked = 0;
	int						restarts = 0;
	int						drops = 0;

	link_quality_monitor i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .params(params), .link_100_valid(link_ok),
		.signal_detect_option(sd_opt), .link_quality_irq_en(irq_en), .dsp_restart(dsp_restart),
		.link_drop(link_drop), .irq(irq));

	// free-running 50 MHz clock
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// pulse counters, so a doubled or lost restart shows up
	always @(posedge clk_sys)
	begin
		restarts <= restarts + int'(dsp_restart);
		drops <= drops + int'(link_drop);
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata & m, e);
	endtask : rd

	// push one parameter out of range, then back inside its thresholds
	task automatic viol(input int i, input logic [7:0] v);
		@(posedge clk_sys);
		params[8*i +: 8] <= v;
		repeat (3) @(posedge clk_sys);
		params <= '0;
		repeat (3) @(posedge clk_sys);
	endtask : viol

	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	// watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		end_of_test();
	end

	initial
	begin
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd(5'h1D, 16'h0000);
		rd(5'h00, 16'h0000);
		for (int i = 0; i < 5; i++)
		begin
			wr(5'h1E, {4'h1, i[2:0], 1'b0, 8'hF6});
			wr(5'h1E, {4'h1, i[2:0], 1'b1, 8'h0A});
		end
		rd(5'h1E, 16'h000A, 16'h10FF);
		wr(5'h1C, 16'h0001);
		irq_en <= 1'b1;
		wr(5'h1D, 16'h8000);
		for (int i = 0; i < 10; i++)
		begin
			viol(i / 2, i[0] ? 8'h14 : 8'hEC);
			rd(5'h1D, 16'h8000 | (16'h0001 << i));
			rd(5'h1D, 16'h8000);
		end
		chk({15'h0000, irq}, 16'h0001);
		wr(5'h1F, 16'h0003);
		viol(0, 8'h14);
		rd(5'h1F, 16'h0001);
		wr(5'h1F, 16'h0003);
		viol(0, 8'h14);
		rd(5'h1F, 16'h0000);
		rd(5'h1D, 16'h8002);
		viol(0, 8'h14);
		rd(5'h1F, 16'h0001);
		wr(5'h1F, 16'h0003);
		irq_en <= 1'b0;
		rd(5'h1D, 16'h8002);
		viol(0, 8'h14);
		rd(5'h1F, 16'h0000);
		rd(5'h1D, 16'h8002);
		irq_en <= 1'b1;
		wr(5'h1C, 16'h0000);
		link_ok <= 1'b0;
		viol(0, 8'h14);
		rd(5'h1D, 16'h8000, 16'h8003);
		link_ok <= 1'b1;
		wr(5'h1D, 16'h0000);
		viol(0, 8'h14);
		rd(5'h1D, 16'h0000);
		for (int i = 0; i < 5; i++)
		begin
			sd_opt <= i[0];
			wr(5'h1D, 16'h8000 | (16'h0400 << i));
			viol((i + 1) % 5, 8'h14);
			viol(i, 8'h14);
		end
		chk(restarts[15:0], 16'h0005);
		chk(drops[15:0], 16'h0003);
		rd(5'h1F, 16'h0003);
		wr(5'h1D, 16'h8000);
		rd(5'h1D, 16'h8002, 16'h8003);
		wr(5'h1E, {4'h1, 3'h0, 1'b1, 8'h7F});
		wr(5'h1E, {4'h1, 3'h0, 1'b0, 8'h80});
		viol(0, 8'h7F);
		viol(0, 8'h80);
		rd(5'h1D, 16'h8000, 16'h8003);
		end_of_test();
	end
endmodule : test_link_quality_monitor
